// ### hdl/pewc_host.sv
// host controller for a byte-wide parallel eeprom with page write
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RULE1] memory holds 8192 bytes on thirteen address lines.
// [RULE2] read: chip select and oe low, write strobe high, device drives data.
// [RULE3] data pins float whenever chip select or oe is high.
// [RULE4] write starts with write strobe and chip select low, oe high.
// [RULE5] address latched on the later falling edge.
// [RULE6] data latched on the first rising edge.
// [RULE7] programming ends within 10 ms; reads meanwhile are polls.
// [RULE8] page write loads one to 64 bytes per programming period.
// [RULE9] host loads each next byte within 150 us.
// [RULE10] window expiry starts programming of loaded bytes.
// [RULE11] upper address bits six to twelve fixed during a page.
// [RULE12] low six bits pick the byte; any order, overwrite allowed.
// [RULE13] poll: bit seven inverted until done.
// [RULE14] bit six toggles on each read until done.
// [RULE15] no write with oe low, chip select high or strobe high.
// [RULE16] strobe pulses under 15 ns are ignored.
// [RULE17] lock enabled by three command writes then one write cycle.
// [RULE18] locked writes need the three-write prefix.
// [RULE19] lock persists; only the disable sequence clears it.
// [RULE20] command writes follow page timing and are not stored.
// [RULE21] locked unprefixed write runs the timer, changes nothing.
// [RULE22] high voltage on address nine maps 1fc0-1fff to id area.
// [RULE23] command addresses and data are parameters.
module pewc_host #(
  parameter logic [12:0] CMD_A0 = 13'h1555,
  parameter logic [12:0] CMD_A1 = 13'h0aaa,
  parameter logic [7:0] CMD_D0 = 8'haa,
  parameter logic [7:0] CMD_D1 = 8'h55,
  parameter logic [7:0] CMD_LOCK = 8'ha0,
  parameter logic [7:0] CMD_UNLOCK = 8'h80,
  parameter logic [7:0] CMD_UNLOCK2 = 8'h20,
  parameter int BLC_CYCLES = pewc_pkg::BLC_CYC,
  parameter int WC_CYCLES = pewc_pkg::WC_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire pewc_pkg::pewc_req_t req,
  input wire logic lock_active,
  // user answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic busy,
  // memory pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic hv_a9,
  output logic [12:0] address_lines,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [7:0] data_pins_i
);
  typedef enum logic [2:0] {
    PEWC_IDLE = 3'h0,
    PEWC_PREFIX = 3'h1,
    PEWC_LOAD = 3'h2,
    PEWC_GAP = 3'h3,
    PEWC_POLL = 3'h4,
    PEWC_READ = 3'h5
  } pewc_state_t;

  pewc_state_t state_r;
  pewc_pkg::pewc_pins_t pins;
  logic [7:0] s1_r, s2_r;
  logic [7:0] rdata;
  logic st_start, st_wr, st_done;
  logic [12:0] st_addr;
  logic [7:0] st_data;
  logic [2:0] pre_idx_r, pre_len_r;
  logic [6:0] page_cnt_r;
  logic [6:0] page_hi_r;
  logic [7:0] last_data_r;
  logic [12:0] last_addr_r;
  logic [7:0] prev_rd_r;
  logic poll_first_r;
  logic [31:0] gap_r;
  logic [31:0] wc_r;
  logic accept, hv_r, last_r;
  pewc_pkg::pewc_op_t op_r;
  logic [7:0] cmd_d;
  logic [12:0] cmd_a;

  // data pins come from the far side: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (clk_en) begin
      s1_r <= data_pins_i;
      s2_r <= s1_r;
    end
  end

  // command step decode, shared by lock, unlock and prefix [RULE23] [RULE20]
  function automatic logic [20:0] cmd_step(input logic [2:0] idx, input pewc_pkg::pewc_op_t op);
    case (idx)
      3'h0: cmd_step = {CMD_A0, CMD_D0};
      3'h1: cmd_step = {CMD_A1, CMD_D1};
      3'h2: cmd_step = {CMD_A0, (op == pewc_pkg::PEWC_OP_UNLOCK) ? CMD_UNLOCK : CMD_LOCK};
      3'h3: cmd_step = {CMD_A0, CMD_D0};
      3'h4: cmd_step = {CMD_A1, CMD_D1};
      default: cmd_step = {CMD_A0, CMD_UNLOCK2};
    endcase
  endfunction : cmd_step

  assign {cmd_a, cmd_d} = cmd_step(pre_idx_r, op_r);

  pewc_strobe u_strobe (
    .clk(clk),
    .rst(rst),
    .ce(clk_en),
    .start(st_start),
    .is_write(st_wr),
    .addr(st_addr),
    .wdata(st_data),
    .hv_a9(hv_r),
    .done(st_done),
    .rdata_r(rdata),
    .pins_r(pins),
    .data_pins_sync(s2_r)
  );

  assign ce_n = pins.ce_n;
  assign oe_n = pins.oe_n;
  assign we_n = pins.we_n;
  assign hv_a9 = pins.hv_a9;
  assign address_lines = pins.address_lines;
  assign data_pins_o = pins.data_out;
  assign data_pins_oe = pins.data_oe;

  // a page byte is taken only while the window is open and the page matches
  assign accept = req_valid && (state_r == PEWC_GAP) && req.op == pewc_pkg::PEWC_OP_WRITE &&
                  req.addr[12:6] == page_hi_r && page_cnt_r < 7'(pewc_pkg::PAGE_BYTES); // [RULE11] [RULE8]
  assign req_ready = (state_r == PEWC_IDLE) || accept;
  assign busy = state_r != PEWC_IDLE;

  always_comb begin
    st_start = 1'b0;
    st_wr = 1'b1;
    st_addr = cmd_a;
    st_data = cmd_d;
    case (state_r)
      PEWC_PREFIX: st_start = 1'b1; // [RULE17] [RULE18]
      PEWC_LOAD: begin
        st_start = 1'b1;
        st_addr = last_addr_r;
        st_data = last_data_r;
      end
      PEWC_POLL, PEWC_READ: begin
        // no poll read may still run when the wait expires [RULE7]
        st_start = state_r == PEWC_READ ||
                   wc_r + 32'(pewc_pkg::READ_CYC + pewc_pkg::FLOAT_CYC + 4) <= 32'(WC_CYCLES);
        st_wr = 1'b0;
        st_addr = last_addr_r;
        st_data = last_data_r;
      end
      default: st_start = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PEWC_IDLE;
      pre_idx_r <= '0;
      pre_len_r <= '0;
      page_cnt_r <= '0;
      page_hi_r <= '0;
      last_addr_r <= '0;
      last_data_r <= '0;
      op_r <= pewc_pkg::PEWC_OP_READ;
      hv_r <= 1'b0;
      last_r <= 1'b0;
      gap_r <= '0;
      wc_r <= '0;
      poll_first_r <= 1'b0;
      prev_rd_r <= '0;
    end else if (clk_en) begin
      case (state_r)
        PEWC_IDLE: if (req_valid) begin
          op_r <= req.op;
          last_addr_r <= req.addr;
          last_data_r <= req.data;
          hv_r <= req.id_area; // [RULE22]
          last_r <= req.last;
          page_hi_r <= req.addr[12:6];
          pre_idx_r <= '0;
          page_cnt_r <= '0;
          case (req.op)
            pewc_pkg::PEWC_OP_READ: state_r <= PEWC_READ;
            pewc_pkg::PEWC_OP_WRITE: if (lock_active) begin
              pre_len_r <= 3'(pewc_pkg::SEQ_LEN); // [RULE18] [RULE21]
              state_r <= PEWC_PREFIX;
            end else begin
              state_r <= PEWC_LOAD;
            end
            pewc_pkg::PEWC_OP_LOCK: begin
              pre_len_r <= 3'(pewc_pkg::SEQ_LEN);
              state_r <= PEWC_PREFIX;
            end
            default: begin
              pre_len_r <= 3'h6; // [RULE19]
              state_r <= PEWC_PREFIX;
            end
          endcase
        end
        PEWC_PREFIX: if (st_done) begin
          if (pre_idx_r + 3'h1 == pre_len_r) begin
            state_r <= (op_r == pewc_pkg::PEWC_OP_WRITE) ? PEWC_LOAD : PEWC_POLL;
            wc_r <= '0;
            poll_first_r <= 1'b1;
            gap_r <= '0;
          end
          pre_idx_r <= pre_idx_r + 3'h1;
        end
        PEWC_LOAD: if (st_done) begin
          page_cnt_r <= page_cnt_r + 7'h1;
          gap_r <= '0;
          // last flag taken with its byte; req may already hold the next one
          state_r <= last_r ? PEWC_POLL : PEWC_GAP;
          poll_first_r <= 1'b1;
          wc_r <= '0;
        end
        PEWC_GAP: begin
          gap_r <= gap_r + 32'h1;
          if (accept) begin
            last_addr_r <= req.addr; // [RULE12]
            last_r <= req.last;
            last_data_r <= req.data;
            state_r <= PEWC_LOAD;
          end else if (gap_r >= 32'(BLC_CYCLES)) begin
            state_r <= PEWC_POLL; // [RULE9] [RULE10]
          end
        end
        PEWC_POLL: begin
          wc_r <= wc_r + 32'h1;
          if (st_done) begin
            poll_first_r <= 1'b0;
            prev_rd_r <= rdata;
            // done when bit six stops toggling and, for an unlocked write, bit seven matches the written data [RULE13] [RULE14]
            if (!poll_first_r && rdata[pewc_pkg::TOGGLE_BIT] == prev_rd_r[pewc_pkg::TOGGLE_BIT]
                && (op_r != pewc_pkg::PEWC_OP_WRITE || lock_active ||
                    rdata[pewc_pkg::POLL_BIT] == last_data_r[pewc_pkg::POLL_BIT]))
              state_r <= PEWC_IDLE;
          end
          if (wc_r >= 32'(WC_CYCLES)) state_r <= PEWC_IDLE; // [RULE7] [RULE17]
        end
        PEWC_READ: if (st_done) state_r <= PEWC_IDLE; // [RULE1] [RULE2]
        default: state_r <= PEWC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else if (clk_en) begin
      rsp_valid <= state_r == PEWC_READ && st_done;
      if (state_r == PEWC_READ && st_done) rsp_data <= rdata;
    end
  end

  AST_PAGE_LIMIT: assert property (@(posedge clk) disable iff (rst)
    page_cnt_r <= 7'd64) else $error("page holds more than 64 bytes"); // [RULE8]
  AST_SAME_PAGE: assert property (@(posedge clk) disable iff (rst)
    $fell(we_n) && state_r == PEWC_LOAD |-> address_lines[12:6] == page_hi_r)
    else $error("page bits changed during load"); // [RULE11]
  AST_GAP_BOUND: assert property (@(posedge clk) disable iff (rst)
    state_r == PEWC_GAP && clk_en && gap_r >= 32'(BLC_CYCLES) && !accept |=> state_r == PEWC_POLL)
    else $error("load window not closed"); // [RULE10]
  AST_WC_BOUND: assert property (@(posedge clk) disable iff (rst)
    state_r == PEWC_POLL && clk_en && wc_r >= 32'(WC_CYCLES) |=> state_r == PEWC_IDLE)
    else $error("write cycle wait overran"); // [RULE7]
  AST_READ_ANSWER: assert property (@(posedge clk) disable iff (rst)
    state_r == PEWC_READ && st_done |=> rsp_valid && rsp_data == $past(rdata))
    else $error("read answer lost"); // [RULE2]
  AST_LOCKED_PREFIX: assert property (@(posedge clk) disable iff (rst)
    state_r == PEWC_IDLE && req_valid && clk_en && lock_active &&
    req.op == pewc_pkg::PEWC_OP_WRITE |=> state_r == PEWC_PREFIX)
    else $error("locked write without prefix"); // [RULE18]
endmodule : pewc_host
`default_nettype wire

// ### hdl/pewc_pkg.sv
// package: constants and carriers for the parallel eeprom host controller
package pewc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_LSB = 6;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int CLK_PERIOD_PS = 5000;
  // strobe low width, setup and hold are counted in clock cycles
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_NS = 150;
  localparam int READ_CYC = (READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_NS = 50;
  localparam int FLOAT_CYC = (FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BLC_US = 150;
  // longest time: round down, keep margin for gaps between bytes
  localparam int BLC_CYC = (BLC_US * 1000000) / CLK_PERIOD_PS / 2;
  localparam int WC_MS = 10;
  // counted in ns so the product stays inside 32 bits
  localparam int WC_CYC = (WC_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int CNT_W = 24;
  localparam int SEQ_LEN = 3;
  localparam logic [12:0] ID_BASE = 13'h1fc0;

  typedef enum logic [1:0] {
    PEWC_OP_READ = 2'h0,
    PEWC_OP_WRITE = 2'h1,
    PEWC_OP_LOCK = 2'h2,
    PEWC_OP_UNLOCK = 2'h3
  } pewc_op_t;

  typedef struct packed {
    pewc_op_t op;
    logic last;
    logic id_area;
    logic [12:0] addr;
    logic [7:0] data;
  } pewc_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hv_a9;
    logic [12:0] address_lines;
    logic [7:0] data_out;
    logic data_oe;
  } pewc_pins_t;
endpackage : pewc_pkg

// ### hdl/pewc_strobe.sv
// one bus cycle on the memory pins: write strobe or read sample
`timescale 1ns/10ps
`default_nettype none
module pewc_strobe (
  // clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  input wire logic hv_a9,
  output logic done,
  output logic [7:0] rdata_r,
  // pins
  output pewc_pkg::pewc_pins_t pins_r,
  input wire logic [7:0] data_pins_sync
);
  localparam int CW = 8;
  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic wr_r;

  // sequence: setup 1 cycle, strobe low, release, float/hold
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        wr_r <= is_write;
        cnt_r <= is_write ? CW'(pewc_pkg::STROBE_CYC + 2) :
                            CW'(pewc_pkg::READ_CYC + pewc_pkg::FLOAT_CYC + 4);
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) busy_r <= 1'b0;
      end
    end
  end

  assign done = busy_r && cnt_r == 1 && ce;

  // oe stays high across the whole write, so no cycle is ever refused
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hv_a9: 1'b0,
                  address_lines: '0, data_out: '0, data_oe: 1'b0};
    end else if (ce) begin
      if (!busy_r && start) begin
        pins_r.address_lines <= addr;
        pins_r.hv_a9 <= hv_a9;
        pins_r.data_out <= wdata;
        pins_r.data_oe <= is_write;
        pins_r.oe_n <= 1'b1;
        pins_r.we_n <= 1'b1;
        pins_r.ce_n <= 1'b1;
      end else if (busy_r && wr_r) begin
        // strobe width far above the 15 ns filter [RULE4] [RULE16] [RULE15]
        pins_r.ce_n <= !(cnt_r > 1);
        pins_r.we_n <= !(cnt_r > 2 && cnt_r <= CW'(pewc_pkg::STROBE_CYC + 2));
        pins_r.data_oe <= cnt_r > 1;
      end else if (busy_r) begin
        pins_r.ce_n <= !(cnt_r > CW'(pewc_pkg::FLOAT_CYC + 2));
        pins_r.oe_n <= !(cnt_r > CW'(pewc_pkg::FLOAT_CYC + 2));
        if (cnt_r == 1) pins_r.hv_a9 <= 1'b0;
      end else begin
        pins_r.data_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) rdata_r <= '0;
    else if (ce && busy_r && !wr_r && cnt_r == CW'(pewc_pkg::FLOAT_CYC + 3))
      rdata_r <= data_pins_sync; // [RULE2]
  end

  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (rst)
    pins_r.data_oe |-> pins_r.oe_n) else $error("host drives data while oe low"); // [RULE3]
  AST_WE_NOT_WITH_OE: assert property (@(posedge clk) disable iff (rst)
    !pins_r.we_n |-> pins_r.oe_n && !pins_r.ce_n) else $error("write strobe with oe low"); // [RULE15]
endmodule : pewc_strobe
`default_nettype wire

// ### dv/pewc_eeprom_model.sv
// behavioural byte-wide eeprom with page latch, polling and write lock
`timescale 1ns/10ps
`default_nettype none
module pewc_eeprom_model #(
  parameter logic [12:0] CMD_A0 = 13'h1555,
  parameter logic [12:0] CMD_A1 = 13'h0aaa,
  parameter logic [7:0] CMD_D0 = 8'haa,
  parameter logic [7:0] CMD_D1 = 8'h55,
  parameter logic [7:0] CMD_LOCK = 8'ha0,
  parameter logic [7:0] CMD_UNLOCK = 8'h80,
  parameter logic [7:0] CMD_UNLOCK2 = 8'h20,
  parameter int LOAD_WIN = 60,
  parameter int PROG_CYC = 60
) (
  // time base for the internal timers only
  input wire logic clk,
  // memory pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv_a9,
  input wire logic [12:0] addr,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe,
  // host misbehaviour count
  output logic [7:0] viol
);
  logic [7:0] mem [8192];
  logic [7:0] id_mem [64];
  logic [21:0] q [$];
  logic [21:0] lat;
  logic locked = 1'b0;
  logic loading = 1'b0;
  logic tog = 1'b0;
  logic armed = 1'b0;
  logic [7:0] last_d = 8'h00;
  int win = 0;
  int prog = 0;
  realtime t_fall = 0;
  wire strobe_n = ce_n | we_n;
  wire reading = !ce_n && !oe_n && we_n;

  initial begin
    viol = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5a;
    foreach (id_mem[i]) id_mem[i] = 8'hff;
  end

  function automatic logic is_cmd(int i, logic [12:0] a, logic [7:0] d);
    return q[i][20:0] == {a, d};
  endfunction : is_cmd

  task automatic commit;
    int n;
    n = 0;
    if (q.size() >= 6 && is_cmd(0, CMD_A0, CMD_D0) && is_cmd(1, CMD_A1, CMD_D1) &&
        is_cmd(2, CMD_A0, CMD_UNLOCK) && is_cmd(3, CMD_A0, CMD_D0) &&
        is_cmd(4, CMD_A1, CMD_D1) && is_cmd(5, CMD_A0, CMD_UNLOCK2)) begin
      locked = 1'b0;
      n = 6;
    end else if (q.size() >= 3 && is_cmd(0, CMD_A0, CMD_D0) && is_cmd(1, CMD_A1, CMD_D1) &&
        is_cmd(2, CMD_A0, CMD_LOCK)) begin
      locked = 1'b1;
      n = 3;
    end else if (locked) begin
      n = q.size();
    end
    // command bytes skipped, only loaded bytes land
    for (int i = n; i < q.size(); i++) begin
      if (q[i][21]) id_mem[q[i][13:8]] = q[i][7:0];
      else mem[q[i][20:8]] = q[i][7:0];
    end
    q.delete();
    loading = 1'b0;
    prog = PROG_CYC;
  endtask : commit

  // later falling edge of the two strobes latches the address
  always @(negedge strobe_n) begin
    armed = oe_n;
    if (!oe_n) viol++;
    lat[20:8] = addr;
    lat[21] = hv_a9 && addr >= 13'h1fc0;
    t_fall = $realtime;
  end

  // first rising edge latches data; glitches start nothing
  always @(posedge strobe_n) begin
    if (armed && $realtime - t_fall < 15.0) viol++;
    else if (armed) begin
      lat[7:0] = dq_i;
      last_d = dq_i;
      q.push_back(lat);
      loading = 1'b1;
      win = 0;
    end
    armed = 1'b0;
  end

  always @(posedge clk) begin
    if (loading) begin
      win++;
      if (win >= LOAD_WIN) commit();
    end else if (prog > 0) prog--;
  end

  always @(posedge reading) begin
    if (loading || prog > 0) begin
      tog = ~tog;
      dq_o = {~last_d[7], tog, last_d[5:0]};
    end else dq_o = (hv_a9 && addr >= 13'h1fc0) ? id_mem[addr[5:0]] : mem[addr];
  end
  assign dq_oe = reading;
endmodule : pewc_eeprom_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench: host controller against the eeprom model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic lock_active = 1'b0;
  pewc_pkg::pewc_req_t req = '0;
  logic req_ready, rsp_valid, busy, ce_n, oe_n, we_n, hv_a9, data_pins_oe, mdl_oe;
  logic [12:0] address_lines;
  logic [7:0] rsp_data, data_pins_o, mdl_dq, bus, viol;
  logic [7:0] last_bus = 8'h00;
  int err_count = 0;
  int compares = 0;

  initial forever #2.5 clk = ~clk;
  // floating bus shows the inverse of the value seen at the previous clock edge
  assign bus = data_pins_oe ? data_pins_o : mdl_oe ? mdl_dq : ~last_bus;
  always @(posedge clk) last_bus <= bus;
  always @(posedge clk) if (data_pins_oe && mdl_oe) begin
    err_count++;
    $display("mismatch bus_contention expected 0 seen 1");
  end

  pewc_host #(.BLC_CYCLES(20), .WC_CYCLES(400)) i_dut (.clk, .rst, .clk_en(1'b1), .req_valid,
    .req_ready, .req, .lock_active, .rsp_valid, .rsp_data, .busy, .ce_n, .oe_n, .we_n, .hv_a9,
    .address_lines, .data_pins_o, .data_pins_oe, .data_pins_i(bus));
  pewc_eeprom_model i_mem (.clk, .ce_n, .oe_n, .we_n, .hv_a9, .addr(address_lines),
    .dq_i(bus), .dq_o(mdl_dq), .dq_oe(mdl_oe), .viol);

  function automatic logic [7:0] iv(logic [12:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : iv

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic timed_out(string nm);
    err_count++;
    $display("mismatch %s expected done seen timeout", nm);
    tally_and_finish();
  endtask : timed_out

  task automatic issue(pewc_pkg::pewc_op_t op, logic [12:0] a, logic [7:0] d, logic lst,
      logic id);
    int n;
    n = 0;
    // one edge with valid low between two requests
    @(posedge clk);
    #1 req = {op, lst, id, a, d};
    req_valid = 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 5000) timed_out("req_ready");
      @(negedge clk);
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask : issue

  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (n > 20000) timed_out("busy");
    end while (busy !== 1'b0);
  endtask : wait_idle

  task automatic wr(logic [12:0] a, logic [7:0] d, logic id = 1'b0);
    int n;
    issue(pewc_pkg::PEWC_OP_WRITE, a, d, 1'b1, id);
    wait_idle(n);
  endtask : wr

  task automatic rd_chk(string nm, logic [12:0] a, logic [7:0] e, logic id = 1'b0);
    int n;
    n = 0;
    issue(pewc_pkg::PEWC_OP_READ, a, 8'h00, 1'b1, id);
    do begin
      @(posedge clk);
      #1 n++;
      if (n > 500) timed_out("rsp_valid");
    end while (rsp_valid !== 1'b1);
    chk(nm, e, rsp_data);
  endtask : rd_chk

  task automatic t_byte;
    int n;
    issue(pewc_pkg::PEWC_OP_WRITE, 13'h0123, 8'h3c, 1'b1, 1'b0);
    wait_idle(n);
    // ends on the poll, well before the 400 cycle fallback
    chk("poll_done", 8'h01, {7'h0, n < 300});
    rd_chk("byte", 13'h0123, 8'h3c);
  endtask : t_byte

  task automatic t_page;
    int n;
    for (int i = 63; i >= 0; i--) begin
      issue(pewc_pkg::PEWC_OP_WRITE, 13'(13'h0400 + i), 8'(8'ha0 ^ i), i == 0, 1'b0);
    end
    wait_idle(n);
    for (int i = 0; i < 64; i += 21) rd_chk("page", 13'(13'h0400 + i), 8'(8'ha0 ^ i));
  endtask : t_page

  task automatic t_expiry;
    int n;
    issue(pewc_pkg::PEWC_OP_WRITE, 13'h0805, 8'h11, 1'b0, 1'b0);
    issue(pewc_pkg::PEWC_OP_WRITE, 13'h0801, 8'h22, 1'b0, 1'b0);
    issue(pewc_pkg::PEWC_OP_WRITE, 13'h0805, 8'h33, 1'b0, 1'b0);
    wait_idle(n);
    rd_chk("overwrite", 13'h0805, 8'h33);
    rd_chk("other", 13'h0801, 8'h22);
    rd_chk("untouched", 13'h0802, iv(13'h0802));
  endtask : t_expiry

  task automatic t_lock;
    int n;
    issue(pewc_pkg::PEWC_OP_LOCK, 13'h0000, 8'h00, 1'b1, 1'b0);
    wait_idle(n);
    lock_active = 1'b1;
    wr(13'h0123, 8'h77);
    rd_chk("prefixed", 13'h0123, 8'h77);
    lock_active = 1'b0;
    wr(13'h0123, 8'h99);
    rd_chk("unprefixed", 13'h0123, 8'h77);
    rd_chk("cmd_addr", 13'h1555, iv(13'h1555));
    issue(pewc_pkg::PEWC_OP_UNLOCK, 13'h0000, 8'h00, 1'b1, 1'b0);
    wait_idle(n);
    wr(13'h0123, 8'h99);
    rd_chk("unlocked", 13'h0123, 8'h99);
  endtask : t_lock

  task automatic t_id;
    wr(13'h1fc0, 8'h5e, 1'b1);
    wr(13'h1fff, 8'h81, 1'b1);
    rd_chk("id_lo", 13'h1fc0, 8'h5e, 1'b1);
    rd_chk("id_hi", 13'h1fff, 8'h81, 1'b1);
    rd_chk("main_1fc0", 13'h1fc0, iv(13'h1fc0));
  endtask : t_id

  initial begin
    repeat (5) @(posedge clk);
    #1 chk("idle_pins", 8'h0e, {4'h0, ce_n, oe_n, we_n, data_pins_oe});
    rst = 1'b0;
    t_byte();
    t_page();
    t_expiry();
    t_lock();
    t_id();
    chk("host_violations", 8'h00, viol);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
